// ---- core/acr_result_regs.sv ----
// Purpose: debug halt control, shared byte staging and conversion result register
// Assumes: AHB-Lite slave, single word transfers, sequencer supplies raw samples
// Notes: reads take one wait cycle; writes complete with no wait
//
// Summary of operation
// - With run_while_cpu_halted clear and the CPU in break, the block stops and drops triggers.
// - With run_while_cpu_halted set, the block keeps running while the CPU is halted.
// - A byte staging register gives the CPU atomic access to each 16-bit register.
// - One staging register is shared by all 16-bit registers.
// - Software reads and writes the staging register like any 8-bit register.
// - The result low byte sits at the base index and the high byte at base plus one.
// - A sample above the reference saturates to 0x3FF.
// - A sample below zero volts clamps to 0x000.
// - At most 64 samples are summed, so the result never passes 0xFFC0.
// - result_ready_flag clears on a written one or on a result read; a written zero does nothing.
// - window_match_flag sets at conversion end only if the selected compare holds; read or one clears.
//
// Register access over AHB-Lite was decided locally.
`default_nettype none
module acr_result_regs (
    input wire logic hclk,               // bus and block clock
    input wire logic hresetn,            // async reset, active low
    input wire logic hsel,               // slave select
    input wire logic [31:0] haddr,       // byte address
    input wire logic [1:0] htrans,       // transfer type
    input wire logic hwrite,             // write when high
    input wire logic [2:0] hsize,        // transfer size
    input wire logic [31:0] hwdata,      // write data
    input wire logic hready,             // bus ready
    output logic [31:0] hrdata,          // read data
    output logic hreadyout,              // slave ready
    output logic hresp,                  // always OKAY
    input wire logic cpu_halted,         // CPU sits in break debug
    input wire logic event_trigger,      // incoming start event
    input wire logic sample_valid,       // raw sample strobe
    input wire logic [9:0] sample_value, // raw sample
    input wire logic sample_over,        // input above reference
    input wire logic sample_under,       // input below zero volts
    input wire logic [15:0] win_low,     // window low threshold
    input wire logic [15:0] win_high,    // window high threshold
    output logic conv_start,             // gated start pulse to sequencer
    output logic periph_halted,          // block halted by debug
    output logic irq                     // level interrupt
);
    import acr_pkg::*;

    // bus data phase state
    logic dp_act_r, dp_act_nxt;
    logic dp_wr_r, dp_wr_nxt;
    logic [7:0] dp_idx_r, dp_idx_nxt;
    logic rd_wait_r, rd_wait_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic hreadyout_r, hreadyout_nxt;
    logic hresp_r;

    // software registers
    logic run_halted_r, run_halted_nxt;
    logic [7:0] staging_r, staging_nxt;
    logic [1:0] irq_mask_r, irq_mask_nxt;
    logic [1:0] irq_status_r, irq_status_nxt;
    logic [2:0] win_sel_r, win_sel_nxt;
    logic [2:0] sample_cnt_r, sample_cnt_nxt;
    logic irq_r, irq_nxt;

    // conversion state
    logic [15:0] result_r, result_nxt;
    logic [15:0] acc_sum_r, acc_sum_nxt;
    logic [6:0] acc_cnt_r, acc_cnt_nxt;
    logic conv_start_r, conv_start_nxt;
    logic halted_r, halted_nxt;
    logic conv_done;
    logic win_hit;
    logic [9:0] sample_clamped;
    logic [6:0] acc_target;

    logic addr_ok;
    logic rd_access;
    logic wr_access;
    logic res_low_read;

    assign addr_ok = hsel && htrans[1] && hready;
    assign rd_access = rd_wait_r;
    assign wr_access = dp_act_r && dp_wr_r;
    assign res_low_read = rd_access && (dp_idx_r == ACR_IDX_RESULT);

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign irq = irq_r;
    assign conv_start = conv_start_r;
    assign periph_halted = halted_r;

    // bus protocol: writes need no wait, reads one wait cycle
    always_comb begin
        dp_act_nxt = addr_ok;
        dp_wr_nxt = hwrite;
        dp_idx_nxt = haddr[9:2];
        if (!addr_ok) begin
            dp_wr_nxt = 1'b0;
            dp_idx_nxt = dp_idx_r;
        end
        if (|haddr[31:10]) begin
            dp_idx_nxt = 8'hFF;
        end
        rd_wait_nxt = addr_ok && !hwrite;
        hreadyout_nxt = !(addr_ok && !hwrite);
        hrdata_nxt = hrdata_r;
        if (rd_access) begin
            hrdata_nxt = 32'h0000_0000;
            unique case (dp_idx_r)
                ACR_IDX_SAMPLE_CNT: hrdata_nxt[2:0] = sample_cnt_r;
                ACR_IDX_WIN_SEL: hrdata_nxt[2:0] = win_sel_r;
                ACR_IDX_IRQ_MASK: hrdata_nxt[1:0] = irq_mask_r;
                ACR_IDX_IRQ_STATUS: hrdata_nxt[1:0] = irq_status_r;
                ACR_IDX_DEBUG: hrdata_nxt[ACR_BIT_RUN_HALTED] = run_halted_r;
                ACR_IDX_STAGING: hrdata_nxt[7:0] = staging_r;
                ACR_IDX_RESULT: hrdata_nxt[7:0] = result_r[7:0];
                ACR_IDX_RESULT + ACR_IDX_HIGH_OFS: hrdata_nxt[7:0] = staging_r;
                default: hrdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_act_r <= 1'b0;
            dp_wr_r <= 1'b0;
            dp_idx_r <= 8'h00;
            rd_wait_r <= 1'b0;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            dp_act_r <= dp_act_nxt;
            dp_wr_r <= dp_wr_nxt;
            dp_idx_r <= dp_idx_nxt;
            rd_wait_r <= rd_wait_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= hreadyout_nxt;
            hresp_r <= 1'b0;
        end
    end

    // clamp each raw sample before it is summed
    always_comb begin
        sample_clamped = sample_value;
        if (sample_over) begin
            sample_clamped = ACR_SAMPLE_MAX;
        end else if (sample_under) begin
            sample_clamped = ACR_SAMPLE_MIN;
        end
    end

    // number of samples per result, capped at 64
    always_comb begin
        acc_target = 7'h01 << sample_cnt_r;
    end

    // accumulator and debug gating
    always_comb begin
        halted_nxt = cpu_halted && !run_halted_r;
        conv_start_nxt = event_trigger && !halted_nxt;
        acc_sum_nxt = acc_sum_r;
        acc_cnt_nxt = acc_cnt_r;
        result_nxt = result_r;
        conv_done = 1'b0;
        if (sample_valid && !halted_nxt) begin
            acc_sum_nxt = acc_sum_r + {6'h00, sample_clamped};
            acc_cnt_nxt = acc_cnt_r + 7'h01;
            if (acc_cnt_nxt >= acc_target) begin
                result_nxt = acc_sum_nxt;
                acc_sum_nxt = 16'h0000;
                acc_cnt_nxt = 7'h00;
                conv_done = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halted_r <= 1'b0;
            conv_start_r <= 1'b0;
            acc_sum_r <= 16'h0000;
            acc_cnt_r <= 7'h00;
            result_r <= ACR_RST_RESULT;
        end else begin
            halted_r <= halted_nxt;
            conv_start_r <= conv_start_nxt;
            acc_sum_r <= acc_sum_nxt;
            acc_cnt_r <= acc_cnt_nxt;
            result_r <= result_nxt;
        end
    end

    // window comparison on the result about to be committed
    always_comb begin
        win_hit = 1'b0;
        unique case (acr_win_t'(win_sel_r))
            ACR_WIN_NONE: win_hit = 1'b0;
            ACR_WIN_BELOW: win_hit = result_nxt < win_low;
            ACR_WIN_ABOVE: win_hit = result_nxt > win_high;
            ACR_WIN_INSIDE: win_hit = (result_nxt > win_low) && (result_nxt < win_high);
            ACR_WIN_OUTSIDE: win_hit = (result_nxt < win_low) || (result_nxt > win_high);
            default: win_hit = 1'b0;
        endcase
    end

    // software registers, flags and interrupt
    always_comb begin
        run_halted_nxt = run_halted_r;
        staging_nxt = staging_r;
        irq_mask_nxt = irq_mask_r;
        win_sel_nxt = win_sel_r;
        sample_cnt_nxt = sample_cnt_r;
        irq_status_nxt = irq_status_r;
        if (wr_access) begin
            unique case (dp_idx_r)
                ACR_IDX_SAMPLE_CNT: begin
                    sample_cnt_nxt = hwdata[2:0];
                    if (hwdata[2:0] > ACR_ACC_LOG2_MAX) begin
                        sample_cnt_nxt = ACR_ACC_LOG2_MAX;
                    end
                end
                ACR_IDX_WIN_SEL: win_sel_nxt = hwdata[2:0];
                ACR_IDX_IRQ_MASK: irq_mask_nxt = hwdata[1:0];
                ACR_IDX_IRQ_STATUS: irq_status_nxt = irq_status_r & ~hwdata[1:0];
                ACR_IDX_DEBUG: run_halted_nxt = hwdata[ACR_BIT_RUN_HALTED];
                ACR_IDX_STAGING: staging_nxt = hwdata[7:0];
                ACR_IDX_RESULT: staging_nxt = hwdata[7:0];
                default: staging_nxt = staging_r;
            endcase
        end
        if (res_low_read) begin
            staging_nxt = result_r[15:8];
            irq_status_nxt = 2'b00;
        end
        // a new event wins over a clear in the same cycle
        if (conv_done) begin
            irq_status_nxt[ACR_BIT_READY] = 1'b1;
            if (win_hit) begin
                irq_status_nxt[ACR_BIT_WIN] = 1'b1;
            end
        end
        irq_nxt = |(irq_status_nxt & irq_mask_nxt);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_halted_r <= 1'b0;
            staging_r <= ACR_RST_BYTE;
            irq_mask_r <= 2'b00;
            irq_status_r <= 2'b00;
            win_sel_r <= 3'b000;
            sample_cnt_r <= ACR_RST_SAMPLE_CNT;
            irq_r <= 1'b0;
        end else begin
            run_halted_r <= run_halted_nxt;
            staging_r <= staging_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_status_r <= irq_status_nxt;
            win_sel_r <= win_sel_nxt;
            sample_cnt_r <= sample_cnt_nxt;
            irq_r <= irq_nxt;
        end
    end

    default clocking acr_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    halt_drops_event_a: assert property (
        (cpu_halted && !run_halted_r) |=> !conv_start_r
    ) else $error("start passed while halted");

    run_keeps_event_a: assert property (
        (event_trigger && (run_halted_r || !cpu_halted)) |=> conv_start_r
    ) else $error("start lost while running");

    low_read_stages_a: assert property (
        res_low_read |=> (staging_r == $past(result_r[15:8]))
    ) else $error("high byte not staged on low read");

    high_read_staged_a: assert property (
        (rd_access && dp_idx_r == ACR_IDX_RESULT + ACR_IDX_HIGH_OFS)
            |=> (hrdata_r[7:0] == $past(staging_r))
    ) else $error("high byte read not from staging");

    staging_write_a: assert property (
        (wr_access && dp_idx_r == ACR_IDX_STAGING && !res_low_read)
            |=> (staging_r == $past(hwdata[7:0]))
    ) else $error("staging write lost");

    result_limit_a: assert property (
        result_r <= ACR_ACC_MAX
    ) else $error("result above limit");

    over_saturates_a: assert property (
        (sample_valid && sample_over && !halted_nxt && sample_cnt_r == 3'h0)
            |=> (result_r == {6'h00, ACR_SAMPLE_MAX})
    ) else $error("sample not saturated");

    under_clamps_a: assert property (
        (sample_valid && sample_under && !sample_over && !halted_nxt && sample_cnt_r == 3'h0)
            |=> (result_r == 16'h0000)
    ) else $error("sample not clamped");

    ready_set_a: assert property (
        conv_done |=> irq_status_r[ACR_BIT_READY] ##1 irq == |(irq_status_r & irq_mask_r)
    ) else $error("ready flag or irq wrong");

    win_none_a: assert property (
        (win_sel_r == ACR_WIN_NONE && !irq_status_r[ACR_BIT_WIN]) |=> !irq_status_r[ACR_BIT_WIN]
    ) else $error("window flag set with no mode");

    read_clears_a: assert property (
        (res_low_read && !conv_done) |=> (irq_status_r == 2'b00)
    ) else $error("result read did not clear flags");

    low_read_data_a: assert property (
        res_low_read |=> (hrdata_r[7:0] == $past(result_r[7:0]))
    ) else $error("result low byte read wrong");

    read_wait_once_a: assert property (
        !hreadyout_r |=> hreadyout_r
    ) else $error("read wait longer than one cycle");

    halt_freezes_acc_a: assert property (
        halted_nxt |=> $stable(acc_sum_r) && $stable(result_r)
    ) else $error("accumulator moved while halted");

    run_takes_sample_a: assert property (
        (sample_valid && cpu_halted && run_halted_r && sample_cnt_r == 3'h0)
            |=> irq_status_r[ACR_BIT_READY]
    ) else $error("sample lost while running in break");

    write_zero_keeps_a: assert property (
        (wr_access && dp_idx_r == ACR_IDX_IRQ_STATUS && !hwdata[ACR_BIT_READY]
            && irq_status_r[ACR_BIT_READY]) |=> irq_status_r[ACR_BIT_READY]
    ) else $error("written zero cleared ready flag");

    win_hit_sets_a: assert property (
        (conv_done && win_hit) |=> irq_status_r[ACR_BIT_WIN]
    ) else $error("window flag not set on match");
endmodule
`default_nettype wire

// ---- core/acr_pkg.sv ----
// Purpose: shared constants for the converter result and debug register block
// Assumes: registers sit on a 32-bit bus, one aligned word per register index
// Notes: byte address of a register is four times its index
`default_nettype none
package acr_pkg;
    // register indices; byte address = index * 4
    localparam logic [7:0] ACR_IDX_SAMPLE_CNT = 8'h02;
    localparam logic [7:0] ACR_IDX_WIN_SEL = 8'h04;
    localparam logic [7:0] ACR_IDX_IRQ_MASK = 8'h0A;
    localparam logic [7:0] ACR_IDX_IRQ_STATUS = 8'h0B;
    localparam logic [7:0] ACR_IDX_DEBUG = 8'h0C;
    localparam logic [7:0] ACR_IDX_STAGING = 8'h0D;
    localparam logic [7:0] ACR_IDX_RESULT = 8'h10;
    localparam logic [7:0] ACR_IDX_HIGH_OFS = 8'h01;
    // field positions
    localparam int ACR_BIT_RUN_HALTED = 0;
    localparam int ACR_BIT_READY = 0;
    localparam int ACR_BIT_WIN = 1;
    // reset values
    localparam logic [7:0] ACR_RST_BYTE = 8'h00;
    localparam logic [15:0] ACR_RST_RESULT = 16'h0000;
    localparam logic [2:0] ACR_RST_SAMPLE_CNT = 3'h0;
    // conversion limits
    localparam logic [9:0] ACR_SAMPLE_MAX = 10'h3FF;
    localparam logic [9:0] ACR_SAMPLE_MIN = 10'h000;
    localparam logic [2:0] ACR_ACC_LOG2_MAX = 3'h6;
    localparam logic [15:0] ACR_ACC_MAX = 16'hFFC0;
    // bus timing: read data follows one wait cycle
    localparam int ACR_READ_WAIT = 1;

    typedef enum logic [2:0] {
        ACR_WIN_NONE = 3'b000,
        ACR_WIN_BELOW = 3'b001,
        ACR_WIN_ABOVE = 3'b010,
        ACR_WIN_INSIDE = 3'b011,
        ACR_WIN_OUTSIDE = 3'b100
    } acr_win_t;
endpackage
`default_nettype wire

// ---- dv/acr_sample_src.sv ----
// Purpose: sequencer-side source of raw converter samples
// Assumes: at most one sample per clock, driven just after a rising edge
// Notes: between bursts the value lines invert so stale data cannot pass
`default_nettype none
module acr_sample_src (
    output logic sample_valid,       // sample strobe
    output logic [9:0] sample_value, // raw sample
    output logic sample_over,        // input above reference
    output logic sample_under,       // input below zero volts
    input wire logic hclk            // block clock
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sample_valid = 1'b0;
        sample_value = 10'h000;
        sample_over = 1'b0;
        sample_under = 1'b0;
    end
    task automatic send(input int n, input logic [9:0] v, input logic ov, input logic un);
        repeat (n) begin
            @(posedge hclk);
            sample_valid <= 1'b1;
            sample_value <= v;
            sample_over <= ov;
            sample_under <= un;
        end
        @(posedge hclk);
        sample_valid <= 1'b0;
        sample_value <= ~v;
        sample_over <= 1'b0;
        sample_under <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dv/test_acr_result_regs.sv ----
// Purpose: self-checking bench for the result and debug register block
// Assumes: one AHB-Lite master, sample source model on the sequencer side
// Notes: a monitor checks each read against a queue of expected words
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_acr_result_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import acr_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic cpu_halted = 1'b0;
    logic event_trigger = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic [15:0] win_low = 16'h0000;
    logic [15:0] win_high = 16'h0000;
    logic [31:0] hrdata, exp_w;
    logic hreadyout, hresp, conv_start, periph_halted, irq;
    logic sample_valid, sample_over, sample_under;
    logic [9:0] sample_value, v;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'hBD8839BA;
    logic rd_dp = 1'b0;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [9:0] vals[4] = '{10'h050, 10'h100, 10'h200, 10'h3F0};

    always #25 hclk = ~hclk;

    acr_result_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cpu_halted(cpu_halted), .event_trigger(event_trigger),
        .sample_valid(sample_valid), .sample_value(sample_value),
        .sample_over(sample_over), .sample_under(sample_under), .win_low(win_low),
        .win_high(win_high), .conv_start(conv_start), .periph_halted(periph_halted),
        .irq(irq));
    acr_sample_src src (.sample_valid(sample_valid), .sample_value(sample_value),
        .sample_over(sample_over), .sample_under(sample_under), .hclk(hclk));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic win_hit(input int m, input logic [15:0] r);
        case (m)
            1: return r < win_low;
            2: return r > win_high;
            3: return (r > win_low) && (r < win_high);
            4: return (r < win_low) || (r > win_high);
            default: return 1'b0;
        endcase
    endfunction

    // one single word transfer; for a read, d is the expected word
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= w ? d : 32'h0;
        if (!w) exp_q.push_back(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic pulse_evt(input logic e);
        @(posedge hclk);
        event_trigger <= 1'b1;
        @(posedge hclk);
        event_trigger <= 1'b0;
        #1;
        `CHK("conv_start", e, conv_start)
    endtask

    task automatic look_irq(input logic e);
        @(posedge hclk);
        #1;
        `CHK("irq", e, irq)
    endtask

    task automatic note(input string s);
        $display("test %s done", s);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            rd_dp <= 1'b0;
            exp_w = exp_q.pop_front();
            `CHK("hrdata", exp_w, hrdata)
            `CHK("hresp", 1'b0, hresp)
        end
        if (hsel && htrans[1] && hreadyout && !hwrite) rd_dp <= 1'b1;
    end

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, 32'h30, 32'h0);
        xfer(1'b0, 32'h34, 32'h0);
        xfer(1'b0, 32'h40, 32'h0);
        xfer(1'b0, 32'h2C, 32'h0);
        note("reset");
        v = 10'(rnd());
        xfer(1'b1, 32'h34, {24'h0, v[7:0]});
        xfer(1'b0, 32'h34, {24'h0, v[7:0]});
        xfer(1'b1, 32'h1000, 32'hFFFFFFFF);
        xfer(1'b0, 32'h1000, 32'h0);
        xfer(1'b1, 32'h40, 32'h5A);
        xfer(1'b0, 32'h34, 32'h5A);
        note("staging");
        xfer(1'b1, 32'h28, 32'h3);
        cpu_halted <= 1'b1;
        look_irq(1'b0);
        `CHK("periph_halted", 1'b1, periph_halted)
        pulse_evt(1'b0);
        src.send(1, 10'h155, 1'b0, 1'b0);
        look_irq(1'b0);
        xfer(1'b0, 32'h2C, 32'h0);
        xfer(1'b1, 32'h30, 32'h1);
        look_irq(1'b0);
        `CHK("periph_halted", 1'b0, periph_halted)
        pulse_evt(1'b1);
        v = 10'(rnd());
        src.send(1, v, 1'b0, 1'b0);
        look_irq(1'b1);
        xfer(1'b0, 32'h40, {24'h0, v[7:0]});
        xfer(1'b0, 32'h44, {30'h0, v[9:8]});
        xfer(1'b0, 32'h34, {30'h0, v[9:8]});
        xfer(1'b0, 32'h2C, 32'h0);
        cpu_halted <= 1'b0;
        note("debug");
        for (int i = 0; i < 3; i++) begin
            src.send(1, 10'(rnd()), i != 1, i != 0);
            look_irq(1'b1);
            xfer(1'b0, 32'h40, (i == 1) ? 32'h0 : 32'hFF);
            xfer(1'b0, 32'h44, (i == 1) ? 32'h0 : 32'h3);
        end
        src.send(1, 10'h011, 1'b0, 1'b0);
        look_irq(1'b1);
        xfer(1'b1, 32'h2C, 32'h0);
        xfer(1'b0, 32'h2C, 32'h1);
        xfer(1'b1, 32'h2C, 32'h1);
        look_irq(1'b0);
        xfer(1'b1, 32'h28, 32'h2);
        xfer(1'b0, 32'h28, 32'h2);
        src.send(1, 10'h022, 1'b0, 1'b0);
        look_irq(1'b0);
        xfer(1'b1, 32'h28, 32'h3);
        look_irq(1'b1);
        xfer(1'b1, 32'h2C, 32'h1);
        look_irq(1'b0);
        note("flags");
        win_low <= 16'h0100;
        win_high <= 16'h0300;
        for (int m = 0; m < 5; m++) begin
            xfer(1'b1, 32'h10, m);
            for (int k = 0; k < 4; k++) begin
                src.send(1, vals[k], 1'b0, 1'b0);
                xfer(1'b0, 32'h2C, {30'h0, win_hit(m, {6'h0, vals[k]}), 1'b1});
                xfer(1'b1, 32'h2C, 32'h3);
            end
        end
        xfer(1'b0, 32'h10, 32'h4);
        src.send(1, 10'h3F0, 1'b0, 1'b0);
        xfer(1'b0, 32'h40, 32'hF0);
        xfer(1'b0, 32'h2C, 32'h0);
        note("window");
        xfer(1'b1, 32'h08, 32'h7);
        xfer(1'b0, 32'h08, 32'h6);
        src.send(64, 10'h2A5, 1'b1, 1'b0);
        look_irq(1'b1);
        xfer(1'b0, 32'h40, 32'hC0);
        xfer(1'b0, 32'h44, 32'hFF);
        note("accumulate");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, 32'h30, 32'h0);
        xfer(1'b0, 32'h34, 32'h0);
        xfer(1'b0, 32'h40, 32'h0);
        xfer(1'b0, 32'h08, 32'h0);
        xfer(1'b0, 32'h28, 32'h0);
        note("reset again");
        give_verdict();
    end
endmodule
`default_nettype wire
